/* File: rtl/isp_port_pkg.sv */
// Purpose: Shared constants and types for the test-access and programming port.
// Assumes: Core clock at 25 MHz; test clock supplied by the external controller.
// Notes: Pulse times are kept in their own units and converted to core cycles here.

package isp_port_pkg;

  // ==========================================================================
  // Instruction codes
  // ==========================================================================
  localparam int unsigned IR_W = 4;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_ENABLE = 4'h9;
  localparam logic [3:0] IR_ERASE = 4'ha;
  localparam logic [3:0] IR_PROGRAM = 4'hb;
  localparam logic [3:0] IR_VERIFY = 4'hc;
  // Value loaded into the instruction shifter on capture (low bits 01).
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  // Instruction held after a test-logic reset.
  localparam logic [3:0] IR_RESET = 4'h1;

  // ==========================================================================
  // Register layout and reset values
  // ==========================================================================
  localparam int unsigned ID_W = 32;
  localparam logic BYPASS_RESET = 1'b0;
  localparam logic ARMED_RESET = 1'b0;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CORE_CLK_KHZ = 25000;
  localparam int unsigned ERASE_PULSE_MS = 100;
  localparam int unsigned PROG_PULSE_MS = 10;
  localparam int unsigned VERIFY_PULSE_US = 10;
  // Least times, rounded up to whole core cycles.
  localparam int unsigned ERASE_CYC_DEF = ERASE_PULSE_MS * CORE_CLK_KHZ;
  localparam int unsigned PROG_CYC_DEF = PROG_PULSE_MS * CORE_CLK_KHZ;
  localparam int unsigned VERIFY_CYC = (VERIFY_PULSE_US * CORE_CLK_KHZ + 999) / 1000;

  // ==========================================================================
  // State types
  // ==========================================================================
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_t;

  typedef enum logic [1:0] {C_IDLE, C_ERASE, C_PROG, C_VERIFY} core_state_t;

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================
  // True for the three commands that need the arming step.
  function automatic logic is_isp_cmd(input logic [3:0] code);
    is_isp_cmd = (code == IR_ERASE) || (code == IR_PROGRAM) || (code == IR_VERIFY);
  endfunction

  // True for every instruction that routes data through the program shift register.
  function automatic logic uses_psr(input logic [3:0] code);
    uses_psr = (code == IR_ENABLE) || is_isp_cmd(code);
  endfunction

  // True where the one-bit bypass stage is the data path, unknown codes included.
  function automatic logic uses_bypass(input logic [3:0] code);
    uses_bypass = (code != IR_IDCODE) && !uses_psr(code);
  endfunction

endpackage

/* File: rtl/nv_row_if.sv */
// Purpose: Row access carrier between the programming controller and the array.
// Assumes: All signals belong to the core clock domain.
// Notes: Read data is valid one cycle after a read strobe.

`timescale 1ns/10ps

interface nv_row_if #(
  parameter int unsigned ADDR_W = 6,
  parameter int unsigned ROW_W = 16
);
  logic we;
  logic re;
  logic [ADDR_W-1:0] addr;
  logic [ROW_W-1:0] wdata;
  logic [ROW_W-1:0] rdata;

  modport ctrl (output we, output re, output addr, output wdata, input rdata);
  modport array (input we, input re, input addr, input wdata, output rdata);
endinterface

/* File: rtl/nv_row_array.sv */
// Purpose: Model of the nonvolatile configuration rows, one word per row.
// Assumes: One write or read per cycle, driven by the programming controller.
// Notes: The array itself has no reset; only the read register does.

`timescale 1ns/10ps

module nv_row_array
  import isp_port_pkg::*;
#(
  parameter int unsigned ADDR_W = 6,
  parameter int unsigned ROW_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Row access
  nv_row_if.array mif
);

  localparam int unsigned ROWS = 2 ** ADDR_W;

  logic [ROW_W-1:0] mem [ROWS];
  logic [ROW_W-1:0] rdata_r;
  logic [ROW_W-1:0] rdata_nxt;

  // ==========================================================================
  // Storage
  // ==========================================================================
  // Rows keep their contents across reset, as a nonvolatile store does.
  always_ff @(posedge core_clk) begin
    if (mif.we) begin
      mem[mif.addr] <= mif.wdata;
    end
  end

  // ==========================================================================
  // Registered read port
  // ==========================================================================
  // The read register only moves on a read strobe.
  always_comb begin
    rdata_nxt = rdata_r;
    if (mif.re) begin
      rdata_nxt = mem[mif.addr];
    end
  end

  // Read register update.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign mif.rdata = rdata_r;

endmodule

/* File: rtl/jtag_isp_command_port.sv */
// Purpose: Test-access port with in-system programming of the configuration rows.
// Assumes: tms and tdi are launched by the controller relative to tck.
// Notes: Link logic runs on tck; row operations run on core_clk behind a toggle handshake.
// What this block does
// RULE_01: Code 1111 puts one-bit bypass on path.
// RULE_02: All-ones instruction scan decodes as bypass.
// RULE_03: Code 0001 shifts identification value out.
// RULE_04: Code 1001 arms erase, program and verify.
// RULE_05: Armed code 1010 erases whole array.
// RULE_06: Armed code 1011 writes shift data to row.
// RULE_07: Armed code 1100 loads addressed row into shifter.
// RULE_08: User pins take configured states during verify.
// RULE_09: Controller arms before commands; arming persists.
// RULE_10: Sample rising edge, drive falling, else float.
// RULE_11: Controller holds mode select high in user mode.
// RULE_12: Power-up reset resets test logic; no test reset.
// RULE_13: Four-bit instruction, standard tap state sequence.
// RULE_14: Unlisted instruction codes behave as bypass.

`timescale 1ns/10ps

module jtag_isp_command_port
  import isp_port_pkg::*;
#(
  parameter int unsigned ADDR_W = 6,
  parameter int unsigned ROW_W = 16,
  parameter int unsigned PIN_W = 8,
  // Identification value; arbitrary, bit 0 set as the scan convention wants.
  parameter logic [31:0] ID_VALUE = 32'h0a5c_0001,
  parameter int unsigned ERASE_CYC = ERASE_CYC_DEF,
  parameter int unsigned PROG_CYC = PROG_CYC_DEF,
  parameter int unsigned CNT_W = 24
) (
  // Core clock and power-up reset
  input wire logic core_clk,
  input wire logic resetn,
  // Test access pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // User pins
  input wire logic [PIN_W-1:0] user_func_out,
  input wire logic [PIN_W-1:0] verify_pin_cfg,
  output logic [PIN_W-1:0] user_pin_out,
  // Status
  output logic isp_busy
);

  localparam int unsigned ROWS = 2 ** ADDR_W;
  localparam int unsigned PSR_W = ADDR_W + ROW_W;

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (ADDR_W < 1 || ROW_W < 1 || PIN_W < 1) begin : g_chk_width
    $error("Widths must be at least one bit.");
  end
  if (ERASE_CYC < ROWS || PROG_CYC < 1 || VERIFY_CYC < 2) begin : g_chk_time
    $error("Pulse counts too short for the row sweep or read latency.");
  end
  if (ERASE_CYC > 2 ** CNT_W || PROG_CYC > 2 ** CNT_W) begin : g_chk_cnt
    $error("Counter too narrow for the pulse counts.");
  end

  // ==========================================================================
  // Test clock reset release
  // ==========================================================================
  logic [1:0] trst_sync_r;
  logic trst_n;

  // Reset asserts at once and releases after two test clock edges.
  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      trst_sync_r <= 2'b00;
    end else begin
      trst_sync_r <= {trst_sync_r[0], 1'b1};
    end
  end
  assign trst_n = trst_sync_r[1];

  // ==========================================================================
  // Test clock domain state
  // ==========================================================================
  tap_state_t st_r, st_nxt;
  logic [IR_W-1:0] irs_r, irs_nxt;
  logic [IR_W-1:0] ir_r, ir_nxt;
  logic byp_r, byp_nxt;
  logic [ID_W-1:0] ids_r, ids_nxt;
  logic [PSR_W-1:0] psr_r, psr_nxt;
  logic armed_r, armed_nxt;
  logic req_tgl_r, req_nxt;
  logic [IR_W-1:0] rcmd_r, rcmd_nxt;
  logic [ADDR_W-1:0] raddr_r, raddr_nxt;
  logic [ROW_W-1:0] rdata_r, rdata_nxt;
  logic dn_s1_r, dn_s2_r, dn_s3_r;
  logic done_evt;
  logic pend;
  logic tdo_src;
  logic tdo_r;
  logic tdo_oe_r;
  // Core domain signals read by the link side.
  logic done_tgl_r;
  logic [ROW_W-1:0] vres_r;

  assign done_evt = dn_s2_r ^ dn_s3_r;
  assign pend = req_tgl_r ^ dn_s2_r;

  // Next state of the tap controller, shifters and command request.
  always_comb begin
    st_nxt = st_r;
    irs_nxt = irs_r;
    ir_nxt = ir_r;
    byp_nxt = byp_r;
    ids_nxt = ids_r;
    psr_nxt = psr_r;
    armed_nxt = armed_r;
    req_nxt = req_tgl_r;
    rcmd_nxt = rcmd_r;
    raddr_nxt = raddr_r;
    rdata_nxt = rdata_r;
    // Standard state walk steered by tms on each rising tck.
    case (st_r) // RULE_13
      TLR: st_nxt = tms ? TLR : RTI;
      RTI: st_nxt = tms ? SEL_DR : RTI;
      SEL_DR: st_nxt = tms ? SEL_IR : CAP_DR;
      CAP_DR: st_nxt = tms ? EX1_DR : SH_DR;
      SH_DR: st_nxt = tms ? EX1_DR : SH_DR;
      EX1_DR: st_nxt = tms ? UPD_DR : PAU_DR;
      PAU_DR: st_nxt = tms ? EX2_DR : PAU_DR;
      EX2_DR: st_nxt = tms ? UPD_DR : SH_DR;
      UPD_DR: st_nxt = tms ? SEL_DR : RTI;
      SEL_IR: st_nxt = tms ? TLR : CAP_IR;
      CAP_IR: st_nxt = tms ? EX1_IR : SH_IR;
      SH_IR: st_nxt = tms ? EX1_IR : SH_IR;
      EX1_IR: st_nxt = tms ? UPD_IR : PAU_IR;
      PAU_IR: st_nxt = tms ? EX2_IR : PAU_IR;
      EX2_IR: st_nxt = tms ? UPD_IR : SH_IR;
      UPD_IR: st_nxt = tms ? SEL_DR : RTI;
      default: st_nxt = TLR;
    endcase
    // Register actions of the current state.
    case (st_r)
      TLR: begin
        ir_nxt = IR_RESET; // RULE_12
        armed_nxt = ARMED_RESET;
      end
      CAP_IR: irs_nxt = IR_CAPTURE;
      SH_IR: irs_nxt = {tdi, irs_r[IR_W-1:1]}; // RULE_02
      UPD_IR: begin
        ir_nxt = irs_r;
        if (irs_r == IR_ENABLE) begin
          armed_nxt = 1'b1; // RULE_04
        end
      end
      CAP_DR: begin
        byp_nxt = BYPASS_RESET;
        ids_nxt = ID_VALUE; // RULE_03
      end
      SH_DR: begin
        if (ir_r == IR_IDCODE) begin
          ids_nxt = {tdi, ids_r[ID_W-1:1]};
        end else if (uses_psr(ir_r)) begin
          psr_nxt = {tdi, psr_r[PSR_W-1:1]};
        end else begin
          byp_nxt = tdi; // RULE_01 RULE_14
        end
      end
      default: begin
      end
    endcase
    // A finished verify drops the row contents into the data field.
    if (done_evt && rcmd_r == IR_VERIFY) begin
      psr_nxt[ROW_W-1:0] = vres_r; // RULE_07
    end
    // Commands go out on the way into idle, only when armed and not busy.
    if ((st_r == UPD_IR || st_r == UPD_DR) && !tms && armed_nxt && is_isp_cmd(ir_nxt)
        && !pend) begin // RULE_09
      req_nxt = ~req_tgl_r;
      rcmd_nxt = ir_nxt;
      raddr_nxt = psr_r[PSR_W-1:ROW_W];
      rdata_nxt = psr_r[ROW_W-1:0];
    end
  end

  // Rising tck registers of the link side.
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      st_r <= TLR;
      irs_r <= IR_CAPTURE;
      ir_r <= IR_RESET;
      byp_r <= BYPASS_RESET;
      ids_r <= '0;
      psr_r <= '0;
      armed_r <= ARMED_RESET;
      req_tgl_r <= 1'b0;
      rcmd_r <= IR_RESET;
      raddr_r <= '0;
      rdata_r <= '0;
    end else begin
      st_r <= st_nxt;
      irs_r <= irs_nxt;
      ir_r <= ir_nxt;
      byp_r <= byp_nxt;
      ids_r <= ids_nxt;
      psr_r <= psr_nxt;
      armed_r <= armed_nxt;
      req_tgl_r <= req_nxt;
      rcmd_r <= rcmd_nxt;
      raddr_r <= raddr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Done toggle from the core passes two flops before the edge detector.
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      dn_s1_r <= 1'b0;
      dn_s2_r <= 1'b0;
      dn_s3_r <= 1'b0;
    end else begin
      dn_s1_r <= done_tgl_r;
      dn_s2_r <= dn_s1_r;
      dn_s3_r <= dn_s2_r;
    end
  end

  // Serial output source picked by state and instruction.
  always_comb begin
    if (st_r == SH_IR) begin
      tdo_src = irs_r[0];
    end else if (ir_r == IR_IDCODE) begin
      tdo_src = ids_r[0];
    end else if (uses_psr(ir_r)) begin
      tdo_src = psr_r[0];
    end else begin
      tdo_src = byp_r;
    end
  end

  // Output changes on falling tck and floats outside the shift states.
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_r <= tdo_src; // RULE_10
      tdo_oe_r <= (st_r == SH_DR) || (st_r == SH_IR); // RULE_10
    end
  end

  assign tdo = tdo_r;
  assign tdo_oe = tdo_oe_r;

  // ==========================================================================
  // Core clock domain: row operations
  // ==========================================================================
  nv_row_if #(.ADDR_W(ADDR_W), .ROW_W(ROW_W)) mif ();

  core_state_t cst_r, cst_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [ADDR_W:0] row_r, row_nxt;
  logic done_nxt;
  logic [ROW_W-1:0] vres_nxt;
  logic [ADDR_W-1:0] cad_r, cad_nxt;
  logic [ROW_W-1:0] cdat_r, cdat_nxt;
  logic rq_s1_r, rq_s2_r, rq_s3_r;
  logic req_evt;
  logic [PIN_W-1:0] pin_r, pin_nxt;
  logic busy_r;

  assign req_evt = rq_s2_r ^ rq_s3_r;

  // Request toggle passes two flops before the edge detector.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rq_s1_r <= 1'b0;
      rq_s2_r <= 1'b0;
      rq_s3_r <= 1'b0;
    end else begin
      rq_s1_r <= req_tgl_r;
      rq_s2_r <= rq_s1_r;
      rq_s3_r <= rq_s2_r;
    end
  end

  // Sequencer for erase sweep, row write and row read with their pulse times.
  always_comb begin
    cst_nxt = cst_r;
    cnt_nxt = cnt_r;
    row_nxt = row_r;
    done_nxt = done_tgl_r;
    vres_nxt = vres_r;
    cad_nxt = cad_r;
    cdat_nxt = cdat_r;
    mif.we = 1'b0;
    mif.re = 1'b0;
    mif.addr = cad_r;
    mif.wdata = cdat_r;
    case (cst_r)
      C_IDLE: begin
        if (req_evt) begin
          cad_nxt = raddr_r;
          cdat_nxt = rdata_r;
          row_nxt = '0;
          case (rcmd_r)
            IR_ERASE: begin
              cst_nxt = C_ERASE;
              cnt_nxt = CNT_W'(ERASE_CYC - 1);
            end
            IR_PROGRAM: begin
              cst_nxt = C_PROG;
              cnt_nxt = CNT_W'(PROG_CYC - 1);
            end
            IR_VERIFY: begin
              cst_nxt = C_VERIFY;
              cnt_nxt = CNT_W'(VERIFY_CYC - 1);
            end
            default: done_nxt = ~done_tgl_r;
          endcase
        end
      end
      C_ERASE: begin
        if (row_r < (ADDR_W + 1)'(ROWS)) begin
          mif.we = 1'b1; // RULE_05
          mif.addr = row_r[ADDR_W-1:0];
          mif.wdata = '1;
          row_nxt = row_r + 1'b1;
        end
      end
      C_PROG: begin
        mif.we = (cnt_r == CNT_W'(PROG_CYC - 1)); // RULE_06
      end
      C_VERIFY: begin
        mif.re = (cnt_r == CNT_W'(VERIFY_CYC - 1));
        if (cnt_r == '0) begin
          vres_nxt = mif.rdata; // RULE_07
        end
      end
      default: cst_nxt = C_IDLE;
    endcase
    // Pulse timer shared by the three operations.
    if (cst_r != C_IDLE) begin
      if (cnt_r == '0) begin
        cst_nxt = C_IDLE;
        done_nxt = ~done_tgl_r;
      end else begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end
    pin_nxt = (cst_nxt == C_VERIFY) ? verify_pin_cfg : user_func_out; // RULE_08
  end

  // Core registers.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cst_r <= C_IDLE;
      cnt_r <= '0;
      row_r <= '0;
      done_tgl_r <= 1'b0;
      vres_r <= '0;
      cad_r <= '0;
      cdat_r <= '0;
      pin_r <= '0;
      busy_r <= 1'b0;
    end else begin
      cst_r <= cst_nxt;
      cnt_r <= cnt_nxt;
      row_r <= row_nxt;
      done_tgl_r <= done_nxt;
      vres_r <= vres_nxt;
      cad_r <= cad_nxt;
      cdat_r <= cdat_nxt;
      pin_r <= pin_nxt;
      busy_r <= (cst_nxt != C_IDLE);
    end
  end

  assign user_pin_out = pin_r;
  assign isp_busy = busy_r;

  nv_row_array #(.ADDR_W(ADDR_W), .ROW_W(ROW_W)) u_rows (
    .core_clk(core_clk),
    .resetn(resetn),
    .mif(mif)
  );

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_ones_ir_scan;
    (st_r == SH_IR && tdi) [*4] ##1 (st_r == EX1_IR) ##1 (st_r == UPD_IR);
  endsequence

  sequence s_tms_high5;
    tms [*5];
  endsequence

  a_bypass_path: assert property ( // RULE_01
    @(posedge tck) disable iff (!trst_n)
    (st_r == SH_DR && ir_r == IR_BYPASS) |=> (tdo_r == $past(tdi)))
    else $error("Bypass stage did not pass tdi through one bit.");

  a_ones_bypass: assert property ( // RULE_02
    @(posedge tck) disable iff (!trst_n)
    s_ones_ir_scan |=> (ir_r == IR_BYPASS))
    else $error("All-ones instruction scan did not select bypass.");

  a_idcode_load: assert property ( // RULE_03
    @(posedge tck) disable iff (!trst_n)
    (st_r == CAP_DR && ir_r == IR_IDCODE) |=> (ids_r == ID_VALUE))
    else $error("Identification value not captured.");

  a_enable_arms: assert property ( // RULE_04
    @(posedge tck) disable iff (!trst_n)
    (st_r == UPD_IR && irs_r == IR_ENABLE) |=> armed_r [*2])
    else $error("Enable instruction did not arm programming.");

  a_cmd_gated: assert property ( // RULE_09
    @(posedge tck) disable iff (!trst_n)
    (req_tgl_r != $past(req_tgl_r)) |-> ($past(armed_nxt) && is_isp_cmd(rcmd_r)))
    else $error("Command issued while not armed.");

  a_erase_sweep: assert property ( // RULE_05
    @(posedge core_clk) disable iff (!resetn)
    $rose(cst_r == C_ERASE) |-> (mif.we && mif.addr == '0 && mif.wdata == '1)
    ##1 (mif.we && mif.addr == ADDR_W'(1)))
    else $error("Erase did not sweep rows from zero.");

  a_program_row: assert property ( // RULE_06
    @(posedge core_clk) disable iff (!resetn)
    $rose(cst_r == C_PROG) |-> (mif.we && mif.addr == cad_r && mif.wdata == cdat_r)
    ##1 !mif.we)
    else $error("Program did not write the addressed row once.");

  a_verify_load: assert property ( // RULE_07
    @(posedge tck) disable iff (!trst_n)
    (done_evt && rcmd_r == IR_VERIFY) |=> (psr_r[ROW_W-1:0] == $past(vres_r)))
    else $error("Verify result not loaded into the shift register.");

  a_verify_pins: assert property ( // RULE_08
    @(posedge core_clk) disable iff (!resetn)
    (cst_r == C_VERIFY) |-> (user_pin_out == $past(verify_pin_cfg)))
    else $error("User pins not at configured states during verify.");

  a_tdo_float: assert property ( // RULE_10
    @(posedge tck) disable iff (!trst_n)
    tdo_oe == (st_r == SH_DR || st_r == SH_IR))
    else $error("Serial output enable outside shift states.");

  a_reset_state: assert property ( // RULE_12
    @(posedge tck) disable iff (!trst_n)
    (st_r == TLR) |=> (ir_r == IR_RESET && !armed_r))
    else $error("Test logic reset did not restore instruction and arming.");

  a_tap_reset: assert property ( // RULE_13
    @(posedge tck) disable iff (!trst_n)
    s_tms_high5 |=> (st_r == TLR))
    else $error("Five tms highs did not reach test logic reset.");

  a_unknown_bypass: assert property ( // RULE_14
    @(posedge tck) disable iff (!trst_n)
    (st_r == SH_DR && uses_bypass(ir_r)) |=> (tdo_r == $past(tdi)))
    else $error("Unlisted instruction did not act as bypass.");

endmodule

/* File: dv/jtag_ctl_model.sv */
// Purpose: Test controller model that drives the scan pins.
// Assumes: Pins have pull-ups, so released lines read high.
// Notes: The test clock runs only inside frames.
`timescale 1ns/10ps
module jtag_ctl_model (
  // Scan pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  // Scan result
  output logic [31:0] rx_data,
  output logic rx
);
  // Lines rest high, clock rests low.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    rx = 1'b0;
    rx_data = '0;
  end
  // One clock; pins change just after the falling edge, so no line is set twice in a step.
  // The output is taken at the rising edge; a released line reads high through its pull-up.
  task automatic clk1(input logic m, input logic d, output logic o);
    #1 tms = m;
    tdi = d;
    #6.5 tck = 1'b1;
    o = tdo_oe ? tdo : 1'b1;
    #7.5 tck = 1'b0;
  endtask
  // Clocks in the run state, then mode select is released high.
  task automatic idle(input int n);
    logic o;
    repeat (n) clk1(1'b0, 1'b1, o);
    tms = 1'b1;
  endtask
  // Five or more high mode clocks reach the reset state.
  task automatic walk_reset();
    logic o;
    repeat (6) clk1(1'b1, 1'b1, o);
    idle(1);
  endtask
  // Full scan from the run state and back, least bit first.
  task automatic scan(input logic ir, input int n, input logic [31:0] din, input logic chk);
    logic o;
    logic [31:0] q;
    q = '0;
    clk1(1'b1, 1'b1, o);
    if (ir) clk1(1'b1, 1'b1, o);
    repeat (2) clk1(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      clk1(i == n - 1, din[i], o);
      q[i] = o;
    end
    clk1(1'b1, 1'b1, o);
    idle(1);
    rx_data = q;
    if (chk) begin
      rx = 1'b1;
      #1 rx = 1'b0;
    end
  endtask
endmodule

/* File: dv/testbench.sv */
// Purpose: Self-checking bench for the test-access and programming port.
// Assumes: Short erase and program counts.
// Notes: Scan results are checked against a queue of expected values.
`timescale 1ns/10ps
module testbench;
  import isp_port_pkg::*;
  // Identification value the block carries by default; arbitrary, bit 0 set.
  localparam logic [31:0] ID_V = 32'h0a5c_0001;
  logic core_clk, resetn, tck, tms, tdi, tdo, tdo_oe, isp_busy, rx, pin_chk;
  logic [7:0] cfg_v, pins;
  logic [7:0] func_v = 8'h00;
  logic [31:0] rx_data;
  logic [15:0] lf = 16'h001f;
  logic [15:0] d1;
  logic [31:0] exp_q[$];
  int err_total, n_compared;
  jtag_isp_command_port #(.ERASE_CYC(80), .PROG_CYC(20)) dut_u (
    .core_clk(core_clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .user_func_out(func_v), .verify_pin_cfg(cfg_v),
    .user_pin_out(pins), .isp_busy(isp_busy));
  jtag_ctl_model ctl_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .rx_data(rx_data), .rx(rx));
  // Core clock at 25 MHz.
  initial begin
    core_clk = 1'b1;
    forever #20 core_clk = ~core_clk;
  end
  function automatic logic [15:0] step(input logic [15:0] s);
    step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic bad(input string m);
    err_total++;
    $display("BAD t=%0t %s", $time, m);
  endtask
  task automatic cmp_scan(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) bad($sformatf("scan exp %h got %h", e, g));
  endtask
  task automatic cmp_pins(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) bad($sformatf("pins exp %h got %h", e, g));
  endtask
  task automatic cmp_flag(input logic e, input logic g);
    n_compared++;
    if (g !== e) bad("busy flag wrong");
  endtask
  // Random user values each falling edge; pins follow half a cycle later, at the next rising edge.
  always @(negedge core_clk) begin
    if (pin_chk && resetn) cmp_pins(func_v, pins);
    lf = step(lf);
    func_v = lf[7:0];
  end
  // Each scan result meets the oldest expectation.
  always @(posedge rx) begin
    if (exp_q.size() == 0) bad("unexpected scan");
    else cmp_scan(exp_q.pop_front(), rx_data);
  end
  task automatic ir(input logic [3:0] c);
    exp_q.push_back({28'h0, IR_CAPTURE});
    ctl_u.scan(1'b1, 4, (c == 4'hf) ? 32'hffff_ffff : {28'h0, c}, 1'b1);
  endtask
  task automatic dr(input int n, input logic [31:0] d, input logic [31:0] e);
    exp_q.push_back(e);
    ctl_u.scan(1'b0, n, d, 1'b1);
  endtask
  // Waits out one row operation, keeping the test clock running for the handshake.
  task automatic op(input logic vfy);
    int i;
    i = 0;
    while (isp_busy !== 1'b1 && i < 40) begin
      ctl_u.idle(1);
      i++;
    end
    cmp_flag(1'b1, isp_busy);
    if (vfy) begin
      ctl_u.idle(10);
      cmp_pins(cfg_v, pins);
    end
    while (isp_busy !== 1'b0 && i < 20000) begin
      ctl_u.idle(1);
      i++;
    end
    cmp_flag(1'b0, isp_busy);
    ctl_u.idle(6);
  endtask
  task automatic test_done();
    if (exp_q.size() != 0) bad("missing scan");
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #400_000;
    bad("timeout");
    test_done();
  end
  initial begin
    resetn = 1'b0;
    cfg_v = lf[15:8];
    pin_chk = 1'b0;
    err_total = 0;
    n_compared = 0;
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    ctl_u.walk_reset();
    pin_chk = 1'b1;
    dr(32, 32'h0, ID_V);
    for (int c = 0; c < 16; c++) begin
      if (!(c inside {1, 9, 10, 11, 12})) begin
        ir(c[3:0]);
        dr(8, {24'h0, lf[7:0]}, {24'h0, lf[6:0], 1'b0});
      end
    end
    ir(IR_ERASE);
    ctl_u.idle(30);
    cmp_flag(1'b0, isp_busy);
    pin_chk = 1'b0;
    ir(IR_ENABLE);
    ir(IR_ERASE);
    op(1'b0);
    d1 = lf;
    ir(IR_ENABLE);
    ctl_u.scan(1'b0, 22, {10'h0, 6'h2a, d1}, 1'b0);
    ir(IR_PROGRAM);
    op(1'b0);
    @(negedge core_clk);
    cfg_v = lf[15:8];
    ir(IR_VERIFY);
    op(1'b1);
    dr(22, {10'h0, 6'h15, 16'h0}, {10'h0, 6'h2a, d1});
    op(1'b1);
    dr(22, {10'h0, 6'h2a, 16'h0}, {10'h0, 6'h15, 16'hffff});
    op(1'b1);
    @(negedge core_clk);
    resetn = 1'b0;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    ctl_u.walk_reset();
    dr(32, 32'h0, ID_V);
    test_done();
  end
endmodule
